// ==== hw/led_dimmer.sv ====
// Purpose: Sixteen channel 8-bit LED dimmer with AXI4-Lite register access
// Assumes: Single clock, synchronous active low reset, one outstanding access per direction
// Notes:   Register byte address is four times the register index; data in bits 7:0

`timescale 1ns/1ps
`default_nettype none

module led_dimmer (
    input  wire logic                                  aclk,
    input  wire logic                                  aresetn,
    input  wire logic [led_dimmer_pkg::ADDR_W-1:0]     s_axi_awaddr,
    input  wire logic                                  s_axi_awvalid,
    output logic                                       s_axi_awready,
    input  wire logic [31:0]                           s_axi_wdata,
    input  wire logic [3:0]                            s_axi_wstrb,
    input  wire logic                                  s_axi_wvalid,
    output logic                                       s_axi_wready,
    output logic [1:0]                                 s_axi_bresp,
    output logic                                       s_axi_bvalid,
    input  wire logic                                  s_axi_bready,
    input  wire logic [led_dimmer_pkg::ADDR_W-1:0]     s_axi_araddr,
    input  wire logic                                  s_axi_arvalid,
    output logic                                       s_axi_arready,
    output logic [31:0]                                s_axi_rdata,
    output logic [1:0]                                 s_axi_rresp,
    output logic                                       s_axi_rvalid,
    input  wire logic                                  s_axi_rready,
    output logic [led_dimmer_pkg::CHANNELS-1:0]        led_out,
    output logic                                       irq
);

    localparam int N = led_dimmer_pkg::CHANNELS;

    // Register decode shared by the write and read paths
    function automatic logic [4:0] decode(input logic [led_dimmer_pkg::ADDR_W-1:0] addr);
        logic [15:0] idx;
        idx = addr[led_dimmer_pkg::ADDR_W-1:2];
        decode = 5'h1F;
        if (idx == led_dimmer_pkg::IDX_CONFIG) begin
            decode = 5'h10;
        end else if (idx == led_dimmer_pkg::IDX_SCALE) begin
            decode = 5'h11;
        end else if (idx == led_dimmer_pkg::IDX_FLAGS) begin
            decode = 5'h12;
        end else if (idx == led_dimmer_pkg::IDX_TRIGGER) begin
            decode = 5'h13;
        end else if (idx >= led_dimmer_pkg::IDX_DUTY0 && idx < led_dimmer_pkg::IDX_DUTY0 + 16'(N)) begin
            decode = {1'b0, 4'(idx - led_dimmer_pkg::IDX_DUTY0)};
        end
    endfunction : decode

    // Bus state
    logic                                 aw_held_q, aw_held_d;
    logic                                 w_held_q, w_held_d;
    logic [led_dimmer_pkg::ADDR_W-1:0]    awaddr_q, awaddr_d;
    logic [7:0]                           wdata_q, wdata_d;
    logic                                 wlane_q, wlane_d;
    logic                                 bvalid_q, bvalid_d;
    logic [1:0]                           bresp_q, bresp_d;
    logic                                 rvalid_q, rvalid_d;
    logic [1:0]                           rresp_q, rresp_d;
    logic [31:0]                          rdata_q, rdata_d;
    logic                                 wr_fire;
    logic [4:0]                           wr_sel;
    logic [4:0]                           rd_sel;

    // Register and engine state
    logic [7:0]                           config_q, config_d;
    logic [7:0]                           scale_q, scale_d;
    logic [7:0]                           trigger_q, trigger_d;
    logic [N-1:0][7:0]                    duty_buf_q, duty_buf_d;
    logic [N-1:0][7:0]                    duty_act_q, duty_act_d;
    logic                                 sync_q, sync_d;
    logic                                 trig_flag_q, trig_flag_d;
    logic                                 zero_flag_q, zero_flag_d;
    logic [7:0]                           count_q, count_d;
    led_dimmer_pkg::run_state_t           state_q, state_d;
    logic                                 tick;
    logic                                 cycle_start;
    logic                                 enable;
    logic                                 group_en;

    assign enable   = config_q[led_dimmer_pkg::CFG_ENABLE_BIT];
    assign group_en = config_q[led_dimmer_pkg::CFG_GROUP_BIT];
    assign wr_fire  = aw_held_q && w_held_q && !bvalid_q;
    assign wr_sel   = decode(awaddr_q);
    assign rd_sel   = decode(s_axi_araddr);

    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready  = !w_held_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;

    // AXI4-Lite handshakes
    always_comb begin
        aw_held_d = aw_held_q;
        w_held_d  = w_held_q;
        awaddr_d  = awaddr_q;
        wdata_d   = wdata_q;
        wlane_d   = wlane_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q;
        rresp_d   = rresp_q;
        rdata_d   = rdata_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_d = 1'b1;
            awaddr_d  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_d = 1'b1;
            wdata_d  = s_axi_wdata[7:0];
            wlane_d  = s_axi_wstrb[0];
        end
        if (wr_fire) begin
            aw_held_d = 1'b0;
            w_held_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = (wr_sel == 5'h1F) ? led_dimmer_pkg::RESP_SLVERR : led_dimmer_pkg::RESP_OKAY;
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d  = led_dimmer_pkg::RESP_OKAY;
            rdata_d  = 32'h0000_0000;
            unique case (rd_sel)
                5'h10: rdata_d[7:0] = config_q;
                5'h11: rdata_d[7:0] = scale_q;
                5'h12: rdata_d[7:0] = {sync_q, 5'h00, trig_flag_q, zero_flag_q};
                5'h13: rdata_d[7:0] = trigger_q;
                5'h1F: rresp_d = led_dimmer_pkg::RESP_SLVERR;
                default: rdata_d[7:0] = duty_buf_q[rd_sel[3:0]];
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= 8'h00;
            wlane_q   <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= led_dimmer_pkg::RESP_OKAY;
            rvalid_q  <= 1'b0;
            rresp_q   <= led_dimmer_pkg::RESP_OKAY;
            rdata_q   <= 32'h0000_0000;
        end else begin
            aw_held_q <= aw_held_d;
            w_held_q  <= w_held_d;
            awaddr_q  <= awaddr_d;
            wdata_q   <= wdata_d;
            wlane_q   <= wlane_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rresp_q   <= rresp_d;
            rdata_q   <= rdata_d;
        end
    end

    led_dimmer_prescaler u_prescaler (
        .aclk    (aclk),
        .aresetn (aresetn),
        .run     (state_q != led_dimmer_pkg::ST_IDLE),
        .scale   (scale_q),
        .tick    (tick)
    );

    // Counter, run state, duty transfer and flags
    always_comb begin
        logic wr_ok;
        wr_ok       = wr_fire && wlane_q;
        config_d    = config_q;
        scale_d     = scale_q;
        trigger_d   = trigger_q;
        duty_buf_d  = duty_buf_q;
        duty_act_d  = duty_act_q;
        sync_d      = sync_q;
        trig_flag_d = trig_flag_q;
        zero_flag_d = zero_flag_q;
        count_d     = count_q;
        state_d     = state_q;
        cycle_start = 1'b0;

        unique case (state_q)
            led_dimmer_pkg::ST_IDLE: begin
                count_d = 8'h00;
                if (enable) begin
                    state_d     = led_dimmer_pkg::ST_RUN;
                    cycle_start = 1'b1;
                end
            end
            led_dimmer_pkg::ST_RUN, led_dimmer_pkg::ST_DRAIN: begin
                if (tick) begin
                    count_d = count_q + 8'h01;
                    if (count_q == led_dimmer_pkg::COUNT_LAST) begin
                        if (enable) begin
                            cycle_start = 1'b1;
                        end else begin
                            state_d = led_dimmer_pkg::ST_IDLE;
                        end
                    end
                end
                if (!enable && state_d != led_dimmer_pkg::ST_IDLE) begin
                    state_d = led_dimmer_pkg::ST_DRAIN;
                end else if (enable && state_q == led_dimmer_pkg::ST_DRAIN) begin
                    state_d = led_dimmer_pkg::ST_RUN;
                end
            end
            default: state_d = led_dimmer_pkg::ST_IDLE;
        endcase

        if (state_q == led_dimmer_pkg::ST_IDLE) begin
            duty_act_d = duty_buf_q;
            sync_d     = 1'b0;
        end else if (cycle_start && (!group_en || sync_q)) begin
            duty_act_d = duty_buf_q;
            sync_d     = 1'b0;
        end

        if (tick && state_q != led_dimmer_pkg::ST_IDLE && count_q == trigger_q) begin
            trig_flag_d = 1'b1;
        end
        if (cycle_start) begin
            zero_flag_d = 1'b1;
        end

        if (wr_ok) begin
            unique case (wr_sel)
                5'h10: config_d  = wdata_q;
                5'h11: scale_d   = wdata_q;
                5'h13: trigger_d = wdata_q;
                5'h12: begin
                    if (wdata_q[led_dimmer_pkg::FLAG_SYNC_BIT]) begin
                        sync_d = 1'b1;
                    end
                    if (wdata_q[led_dimmer_pkg::FLAG_ZERO_BIT] && !cycle_start) begin
                        zero_flag_d = 1'b0;
                    end
                end
                5'h1F: ;
                default: duty_buf_d[wr_sel[3:0]] = wdata_q;
            endcase
        end
        // Trigger flag clear keeps a hit in the same cycle
        if (wr_ok && wr_sel == 5'h12 && wdata_q[led_dimmer_pkg::FLAG_TRIG_BIT]) begin
            trig_flag_d = tick && state_q != led_dimmer_pkg::ST_IDLE && count_q == trigger_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            config_q    <= led_dimmer_pkg::CONFIG_RESET;
            scale_q     <= led_dimmer_pkg::SCALE_RESET;
            trigger_q   <= led_dimmer_pkg::TRIGGER_RESET;
            duty_buf_q  <= {N{led_dimmer_pkg::DUTY_RESET}};
            duty_act_q  <= {N{led_dimmer_pkg::DUTY_RESET}};
            sync_q      <= 1'b0;
            trig_flag_q <= 1'b0;
            zero_flag_q <= 1'b0;
            count_q     <= 8'h00;
            state_q     <= led_dimmer_pkg::ST_IDLE;
        end else begin
            config_q    <= config_d;
            scale_q     <= scale_d;
            trigger_q   <= trigger_d;
            duty_buf_q  <= duty_buf_d;
            duty_act_q  <= duty_act_d;
            sync_q      <= sync_d;
            trig_flag_q <= trig_flag_d;
            zero_flag_q <= zero_flag_d;
            count_q     <= count_d;
            state_q     <= state_d;
        end
    end

    // Flags gated by their enable bits onto one level interrupt
    assign irq = (trig_flag_q && config_q[led_dimmer_pkg::CFG_TRIG_EN_BIT])
              || (zero_flag_q && config_q[led_dimmer_pkg::CFG_ZERO_EN_BIT]);

    dimmer_link_if link ();

    assign link.count       = count_q;
    assign link.running     = state_q != led_dimmer_pkg::ST_IDLE;
    assign link.idle_level  = config_q[led_dimmer_pkg::CFG_MODE_BIT];
    assign link.duty_active = duty_act_q;

    led_dimmer_bank u_bank (
        .aclk    (aclk),
        .aresetn (aresetn),
        .link    (link.bank),
        .led_out (led_out)
    );

endmodule : led_dimmer

`default_nettype wire

// ==== hw/led_dimmer_bank.sv ====
// Purpose: Sixteen compare channels producing the registered LED outputs
// Assumes: Active duties change only at a cycle start while running
// Notes:   Even channels lead the cycle, odd channels trail it

`timescale 1ns/1ps
`default_nettype none

module led_dimmer_bank (
    input  wire logic                                 aclk,
    input  wire logic                                 aresetn,
    dimmer_link_if.bank                               link,
    output logic [led_dimmer_pkg::CHANNELS-1:0]       led_out
);

    logic [led_dimmer_pkg::CHANNELS-1:0] out_d;

    genvar ch;
    generate
        for (ch = 0; ch < led_dimmer_pkg::CHANNELS; ch++) begin : g_chan
            always_comb begin
                if (!link.running) begin
                    out_d[ch] = link.idle_level;
                end else if (ch % 2 == 0) begin
                    out_d[ch] = link.count < link.duty_active[ch];
                end else begin
                    out_d[ch] = (8'hFF - link.count) < link.duty_active[ch];
                end
            end
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            led_out <= '0;
        end else begin
            led_out <= out_d;
        end
    end

endmodule : led_dimmer_bank

`default_nettype wire

// ==== hw/led_dimmer_prescaler.sv ====
// Purpose: Divides the system clock into a one-cycle count tick
// Assumes: Scale value is stable or changes take effect in the current period
// Notes:   Tick period is scale plus one clock cycles

`timescale 1ns/1ps
`default_nettype none

module led_dimmer_prescaler (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       run,
    input  wire logic [7:0] scale,
    output logic            tick
);

    logic [7:0] div_q;
    logic [7:0] div_d;

    always_comb begin
        div_d = div_q;
        tick  = 1'b0;
        if (!run) begin
            div_d = 8'h00;
        end else if (div_q >= scale) begin
            div_d = 8'h00;
            tick  = 1'b1;
        end else begin
            div_d = div_q + 8'h01;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_d;
        end
    end

endmodule : led_dimmer_prescaler

`default_nettype wire

// ==== inc/dimmer_link_if.sv ====
// Purpose: Carries counter, run state and active duties from the core to the output bank
// Assumes: One clock domain
// Notes:   Core drives everything; the bank only reads

`timescale 1ns/1ps
`default_nettype none

interface dimmer_link_if;
    logic [7:0]                                          count;
    logic                                                running;
    logic                                                idle_level;
    logic [led_dimmer_pkg::CHANNELS-1:0][led_dimmer_pkg::DUTY_W-1:0] duty_active;

    modport core (output count, output running, output idle_level, output duty_active);
    modport bank (input count, input running, input idle_level, input duty_active);
endinterface : dimmer_link_if

`default_nettype wire

// ==== inc/led_dimmer_pkg.sv ====
// Purpose: Shared constants and types of the sixteen channel LED dimmer
// Assumes: Register indices are word indices; byte address is four times the index
// Notes:   All widths and positions used by more than one file live here

package led_dimmer_pkg;

    localparam int          CHANNELS        = 16;
    localparam int          DUTY_W          = 8;
    localparam int          ADDR_W          = 18;

    localparam logic [15:0] IDX_CONFIG      = 16'hA04C;
    localparam logic [15:0] IDX_SCALE       = 16'hA04D;
    localparam logic [15:0] IDX_FLAGS       = 16'hA04E;
    localparam logic [15:0] IDX_TRIGGER     = 16'hA04F;
    localparam logic [15:0] IDX_DUTY0       = 16'hA0A0;

    localparam int          CFG_ENABLE_BIT  = 7;
    localparam int          CFG_MODE_BIT    = 6;
    localparam int          CFG_GROUP_BIT   = 4;
    localparam int          CFG_TRIG_EN_BIT = 1;
    localparam int          CFG_ZERO_EN_BIT = 0;

    localparam int          FLAG_SYNC_BIT   = 7;
    localparam int          FLAG_TRIG_BIT   = 1;
    localparam int          FLAG_ZERO_BIT   = 0;

    localparam logic [7:0]  CONFIG_RESET    = 8'h00;
    localparam logic [7:0]  SCALE_RESET     = 8'h00;
    localparam logic [7:0]  TRIGGER_RESET   = 8'h00;
    localparam logic [7:0]  DUTY_RESET      = 8'h00;
    localparam logic [7:0]  COUNT_LAST      = 8'hFF;

    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_RUN   = 2'b01,
        ST_DRAIN = 2'b11
    } run_state_t;

endpackage : led_dimmer_pkg

// ==== test/led_dimmer_monitor.sv ====
// Purpose: Port-level checks of the LED dimmer register bus
// Assumes: Single clock, synchronous active low reset
// Notes:   Bound to every led_dimmer instance

`timescale 1ns/1ps
`default_nettype none

module led_dimmer_monitor (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_read_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_write_latency: assert property (s_write_taken |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_read_latency: assert property (s_read_taken |=> s_axi_rvalid)
        else $error("read data late");
    a_rdata_narrow: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("read data upper bits set");
    a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted during response");
    a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted during data");
    a_bvalid_clears: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_resp_code: assert property (s_axi_rvalid |-> s_axi_rresp inside {2'h0, 2'h2})
        else $error("bad read response code");
endmodule : led_dimmer_monitor

bind led_dimmer led_dimmer_monitor u_mon (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

`default_nettype wire

// ==== test/led_load_model.sv ====
// Purpose: LED loads that tally lit cycles per channel
// Assumes: clr zeroes all tallies at the next edge
// Notes:   Tallies are exact over up to two whole PWM periods at any scale

`timescale 1ns/1ps
`default_nettype none

module led_load_model (
    input  wire logic         aclk,
    input  wire logic         clr,
    input  wire logic [15:0]  led,
    output logic [15:0][16:0] on_cnt
);
    always_ff @(posedge aclk) begin
        for (int i = 0; i < 16; i++) begin
            on_cnt[i] <= clr ? 17'h0_0000 : on_cnt[i] + 17'(led[i]);
        end
    end
endmodule : led_load_model

`default_nettype wire

// ==== test/tb_top.sv ====
// Purpose: Self-checking bench of the sixteen channel LED dimmer
// Assumes: Register bus speaks AXI4-Lite; byte address is four times the index
// Notes:   Duty tallies are taken over whole periods so phase does not matter

`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic aclk = 1'b0, aresetn = 1'b0, clr = 1'b0;
    logic [17:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd_d;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [15:0] led_out, seed = 16'hFAA4;
    logic [15:0][16:0] on_cnt;
    logic [7:0] dty [16];
    logic p;
    int err_count = 0, comparisons = 0, t0, t1;

    always #10 aclk = ~aclk;

    led_dimmer u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .led_out, .irq);
    led_load_model u_load (.aclk, .clr, .led(led_out), .on_cnt);

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic [31:0] lit(input logic [7:0] d, input int m);
        return d * m;
    endfunction : lit

    task automatic summarize();
        $display("comparisons=%0d err_count=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [15:0] i, input logic [7:0] d);
        logic a, w, da, dw, v;
        da = 1'b0;
        dw = 1'b0;
        s_axi_bready <= (i != led_dimmer_pkg::IDX_SCALE);
        s_axi_awaddr <= {i, 2'b00};
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(negedge aclk);
            a = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            @(posedge aclk);
            if (a) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            da |= a;
            dw |= w;
        end while (!(da && dw));
        do begin
            @(negedge aclk);
            v = s_axi_bvalid;
            a = v && s_axi_bready;
            rsp = s_axi_bresp;
            @(posedge aclk);
            if (v && !a) s_axi_bready <= 1'b1;
        end while (!a);
    endtask : wr
    task automatic rchk(input logic [15:0] i, input logic [7:0] e, input logic [1:0] er);
        logic a, v;
        s_axi_rready <= (i != led_dimmer_pkg::IDX_TRIGGER);
        s_axi_araddr <= {i, 2'b00};
        s_axi_arvalid <= 1'b1;
        do begin
            @(negedge aclk);
            a = s_axi_arready;
            @(posedge aclk);
        end while (!a);
        s_axi_arvalid <= 1'b0;
        do begin
            @(negedge aclk);
            v = s_axi_rvalid;
            a = v && s_axi_rready;
            rd_d = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge aclk);
            if (v && !a) s_axi_rready <= 1'b1;
        end while (!a);
        chk(rd_d, {24'h00_0000, e});
        chk({30'h0000_0000, rsp}, {30'h0000_0000, er});
    endtask : rchk
    task automatic win(input int m, input logic [15:0] msk);
        clr <= 1'b1;
        @(posedge aclk);
        clr <= 1'b0;
        repeat (256 * m) @(posedge aclk);
        @(negedge aclk);
        for (int c = 0; c < 16; c++)
            if (msk[c]) chk({15'h0000, on_cnt[c]}, lit(dty[c], m));
        @(posedge aclk);
    endtask : win

    initial begin
        repeat (40000) @(posedge aclk);
        err_count++;
        summarize();
    end

    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int k = 0; k < 4; k++) rchk(led_dimmer_pkg::IDX_CONFIG + 16'(k), 8'h00, 2'h0);
        rchk(led_dimmer_pkg::IDX_DUTY0 + 16'd15, 8'h00, 2'h0);
        rchk(16'h0000, 8'h00, led_dimmer_pkg::RESP_SLVERR);
        wr(16'h0000, 8'h5A);
        chk({30'h0000_0000, rsp}, {30'h0000_0000, led_dimmer_pkg::RESP_SLVERR});
        for (int c = 0; c < 16; c++) begin
            seed = lfsr(seed);
            dty[c] = seed[7:0] | 8'h01;
            wr(led_dimmer_pkg::IDX_DUTY0 + 16'(c), dty[c]);
        end
        for (int c = 0; c < 16; c++) rchk(led_dimmer_pkg::IDX_DUTY0 + 16'(c), dty[c], 2'h0);
        wr(led_dimmer_pkg::IDX_CONFIG, 8'h80);
        repeat (300) @(posedge aclk);
        win(1, 16'hFFFF);
        // Even channel falls after its duty, odd channel rises duty before the period end
        p = 1'b1;
        repeat (600) begin
            @(negedge aclk);
            if (led_out[0] && !p) break;
            p = led_out[0];
        end
        t0 = -1;
        t1 = -1;
        for (int k = 1; k < 256; k++) begin
            @(negedge aclk);
            if (!led_out[0] && t0 < 0) t0 = k;
            if (led_out[1] && t1 < 0) t1 = k;
        end
        chk(t0, {24'h00_0000, dty[0]});
        chk(t1, 32'd256 - dty[1]);
        @(posedge aclk);
        dty[3] = ~dty[3];
        wr(led_dimmer_pkg::IDX_DUTY0 + 16'd3, dty[3]);
        repeat (300) @(posedge aclk);
        win(1, 16'h0008);
        wr(led_dimmer_pkg::IDX_CONFIG, 8'h90);
        wr(led_dimmer_pkg::IDX_DUTY0 + 16'd2, ~dty[2]);
        repeat (300) @(posedge aclk);
        win(1, 16'h0004);
        dty[2] = ~dty[2];
        wr(led_dimmer_pkg::IDX_FLAGS, 8'h80);
        repeat (300) @(posedge aclk);
        rchk(led_dimmer_pkg::IDX_FLAGS, 8'h03, 2'h0);
        win(1, 16'hFFFF);
        wr(led_dimmer_pkg::IDX_SCALE, 8'h01);
        repeat (600) @(posedge aclk);
        win(2, 16'hFFFF);
        seed = lfsr(seed);
        wr(led_dimmer_pkg::IDX_TRIGGER, seed[7:0]);
        wr(led_dimmer_pkg::IDX_FLAGS, 8'h03);
        repeat (1100) @(posedge aclk);
        rchk(led_dimmer_pkg::IDX_FLAGS, 8'h03, 2'h0);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(led_dimmer_pkg::IDX_CONFIG, 8'h42);
        @(negedge aclk);
        chk({31'h0, irq}, 32'h0000_0001);
        @(posedge aclk);
        repeat (1200) @(posedge aclk);
        chk({16'h0000, led_out}, 32'h0000_FFFF);
        wr(led_dimmer_pkg::IDX_FLAGS, 8'h03);
        rchk(led_dimmer_pkg::IDX_FLAGS, 8'h00, 2'h0);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(led_dimmer_pkg::IDX_CONFIG, 8'h00);
        repeat (4) @(posedge aclk);
        chk({16'h0000, led_out}, 32'h0000_0000);
        // Trigger must not fire before the counter reaches its point
        wr(led_dimmer_pkg::IDX_TRIGGER, 8'h80);
        wr(led_dimmer_pkg::IDX_CONFIG, 8'h80);
        repeat (200) @(posedge aclk);
        rchk(led_dimmer_pkg::IDX_FLAGS, 8'h01, 2'h0);
        repeat (200) @(posedge aclk);
        rchk(led_dimmer_pkg::IDX_FLAGS, 8'h03, 2'h0);
        summarize();
    end
endmodule : tb_top

`default_nettype wire
